/* include/lock_alarm_pkg.sv */
// package: constants for the scan alarm compactor
// assumes: 32-bit AXI4-Lite data, one aligned word per register
package lock_alarm_pkg;
  // =========================================================
  // scan sequencing
  localparam int SAMPLES_PER_SCAN = 100;
  localparam logic [6:0] SAMPLE_LAST = 7'(SAMPLES_PER_SCAN - 1);
  localparam logic [6:0] SAMPLE_FIRST = 7'h01;
  // =========================================================
  // alarm vector layout
  localparam int NUM_ALARMS = 6;
  localparam int SYN_HI = 5;
  localparam int SYN_LO = 3;
  localparam int LOOP_HI = 2;
  localparam int LOOP_LO = 0;
  // =========================================================
  // register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_ALARM_BYTE = 8'h00;
  localparam logic [7:0] OFF_LIVE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFF_SCAN_COUNT = 8'h18;
  // =========================================================
  // fields and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int BYTE_VALID_BIT = 8;
  localparam int LIVE_STATE_LO = 8;
  localparam int NUM_EVT = 2;
  localparam int EVT_DONE_BIT = 0;
  localparam int EVT_ABORT_BIT = 1;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;
  localparam logic [7:0] ALARM_BYTE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // =========================================================
  // scan state, gray along idle -> first -> track
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'h0,
    SCAN_FIRST = 2'h1,
    SCAN_TRACK = 2'h3
  } scan_state_t;
endpackage

/* include/alarm_if.sv */
// interface: synchronised alarm vector between synchroniser and core
// assumes: both ends on sys_clk
`timescale 1ns/1ps
interface alarm_if;
  logic [5:0] alarms;
  modport src (output alarms);
  modport dst (input alarms);
endinterface

/* verilog/alarm_sync.sv */
// module: two-flop synchroniser for the six asynchronous alarm pins
// assumes: pins are unrelated to sys_clk; ce freezes the stages
`timescale 1ns/1ps
module alarm_sync (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // raw pins
  input wire logic [5:0] pinAlarm,
  // synchronised side
  alarm_if.src syncOut
);
  import lock_alarm_pkg::*;
  logic [5:0] stage1;
  logic [5:0] stage2;
  logic [5:0] next_stage1;
  logic [5:0] next_stage2;

  // =========================================================
  // stage update
  always_comb begin
    next_stage1 = ce ? pinAlarm : stage1;
    next_stage2 = ce ? stage1 : stage2;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 6'h00;
      stage2 <= 6'h00;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign syncOut.alarms = stage2;
endmodule

/* verilog/lock_alarm_scan_compactor.sv */
// module: per-scan lock/alarm compactor with AXI4-Lite registers
// assumes: scanStart and sampleStrobe come from logic on sys_clk;
// alarm pins are asynchronous and are synchronised here
//
// Functional notes
// - six alarm inputs, three synthesizer locks on top, then submm low, submm high and local osc loop alarms.
// - a synthesizer input reads one when locked and zero in alarm.
// - a loop alarm input reads zero when locked and one in alarm.
// - at the first sample the consolidated synthesizer bit is the AND of the three synthesizer inputs.
// - at the first sample each loop alarm is captured unchanged as its initial state.
// - initial states come from the first sample and the remaining 99 samples are watched for change.
// - the upper nibble holds synthesizer, submm low, submm high and local osc initial states, msb first.
// - a loop alarm change flag sticks at one once its input differs from its initial state.
// - the synthesizer change flag sticks at one once any synthesizer input differs from its own first value.
// - eight bits per scan, change flags in the lower nibble in the same order as the upper nibble.
// - one alarm byte is delivered for every completed scan.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module lock_alarm_scan_compactor (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // alarm pins
  input wire logic [2:0] synthLock,
  input wire logic submmLowLoopAlarm,
  input wire logic submmHighLoopAlarm,
  input wire logic localOscFreqLoopAlarm,
  // sequencer strobes
  input wire logic scanStart,
  input wire logic sampleStrobe,
  // telemetry side
  output logic [7:0] alarmByte,
  output logic byteValid,
  output logic irq,
  // axi4-lite write
  input wire logic [lock_alarm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [lock_alarm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import lock_alarm_pkg::*;

  // =========================================================
  // alarm synchroniser
  alarm_if syncBus ();
  alarm_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .pinAlarm({synthLock, submmLowLoopAlarm, submmHighLoopAlarm,
               localOscFreqLoopAlarm}),
    .syncOut(syncBus.src)
  );
  logic [2:0] synthNow;
  logic [2:0] loopNow;
  assign synthNow = syncBus.alarms[SYN_HI:SYN_LO];
  assign loopNow = syncBus.alarms[LOOP_HI:LOOP_LO];

  // =========================================================
  // scan tracking state
  scan_state_t state, next_state;
  logic [6:0] sampleCount, next_sampleCount;
  logic [2:0] initSynth, next_initSynth, initLoop, next_initLoop;
  logic [2:0] changeLoop, next_changeLoop;
  logic changeSynth, next_changeSynth, next_byteValid;
  logic ctrlEnable, clearPulse;
  logic [7:0] next_alarmByte;
  logic [15:0] scanCount, next_scanCount;
  logic [NUM_EVT-1:0] evtSet;
  always_comb begin
    next_state = state;
    next_sampleCount = sampleCount;
    next_initSynth = initSynth;
    next_initLoop = initLoop;
    next_changeSynth = changeSynth;
    next_changeLoop = changeLoop;
    next_alarmByte = alarmByte;
    next_byteValid = 1'b0;
    next_scanCount = scanCount;
    evtSet = '0;
    if (clearPulse) begin
      next_state = SCAN_IDLE;
      next_sampleCount = 7'h00;
      next_initSynth = 3'h0;
      next_initLoop = 3'h0;
      next_changeSynth = 1'b0;
      next_changeLoop = 3'h0;
      next_alarmByte = ALARM_BYTE_RESET;
      next_scanCount = 16'h0000;
    end else if (ctrlEnable && scanStart) begin
      evtSet[EVT_ABORT_BIT] = (state != SCAN_IDLE);
      next_state = SCAN_FIRST;
      next_sampleCount = 7'h00;
      next_changeSynth = 1'b0;
      next_changeLoop = 3'h0;
    end else if (ctrlEnable && sampleStrobe) begin
      case (state)
        SCAN_FIRST: begin
          next_initSynth = synthNow;
          next_initLoop = loopNow;
          next_sampleCount = SAMPLE_FIRST;
          next_state = SCAN_TRACK;
        end
        SCAN_TRACK: begin
          next_changeSynth = changeSynth | (|(synthNow ^ initSynth));
          next_changeLoop = changeLoop | (loopNow ^ initLoop);
          next_sampleCount = sampleCount + 7'h01;
          if (sampleCount == SAMPLE_LAST) begin
            // synthesizer lock is one, so AND means all locked
            next_alarmByte = {&initSynth, initLoop,
                              next_changeSynth, next_changeLoop};
            next_byteValid = 1'b1;
            next_scanCount = scanCount + 16'h0001;
            evtSet[EVT_DONE_BIT] = 1'b1;
            next_state = SCAN_IDLE;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SCAN_IDLE;
      sampleCount <= 7'h00;
      initSynth <= 3'h0;
      initLoop <= 3'h0;
      changeSynth <= 1'b0;
      changeLoop <= 3'h0;
      alarmByte <= ALARM_BYTE_RESET;
      byteValid <= 1'b0;
      scanCount <= 16'h0000;
    end else if (ce) begin
      state <= next_state;
      sampleCount <= next_sampleCount;
      initSynth <= next_initSynth;
      initLoop <= next_initLoop;
      changeSynth <= next_changeSynth;
      changeLoop <= next_changeLoop;
      alarmByte <= next_alarmByte;
      byteValid <= next_byteValid;
      scanCount <= next_scanCount;
    end
  end
  // =========================================================
  // axi4-lite slave and registers
  logic awHeld, next_awHeld, wHeld, next_wHeld, doWrite, next_irq;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic next_ctrlEnable, next_clearPulse;
  logic [ADDR_W-1:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData, next_rdata;
  logic [3:0] wStrb, next_wStrb;
  logic [1:0] next_bresp, next_rresp;
  logic [NUM_EVT-1:0] irqStatus, next_irqStatus, irqEnable, next_irqEnable;
  logic [NUM_EVT-1:0] irqClear;
  always_comb begin
    next_awHeld = awHeld | (s_axi_awvalid & s_axi_awready);
    next_wHeld = wHeld | (s_axi_wvalid & s_axi_wready);
    next_awAddr = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awAddr;
    next_wData = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wData;
    next_wStrb = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wStrb;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_ctrlEnable = ctrlEnable;
    next_clearPulse = 1'b0;
    next_irqEnable = irqEnable;
    irqClear = '0;
    doWrite = next_awHeld & next_wHeld & ~next_bvalid;
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (next_awAddr == OFF_CTRL) begin
        if (next_wStrb[0]) begin
          next_ctrlEnable = next_wData[CTRL_ENABLE_BIT];
          next_clearPulse = next_wData[CTRL_CLEAR_BIT];
        end
      end else if (next_awAddr == OFF_IRQ_CLEAR) begin
        if (next_wStrb[0]) begin
          irqClear = next_wData[NUM_EVT-1:0];
        end
      end else if (next_awAddr == OFF_IRQ_ENABLE) begin
        if (next_wStrb[0]) begin
          next_irqEnable = next_wData[NUM_EVT-1:0];
        end
      end else if (next_awAddr != OFF_ALARM_BYTE && next_awAddr != OFF_LIVE &&
                   next_awAddr != OFF_IRQ_STATUS &&
                   next_awAddr != OFF_SCAN_COUNT) begin
        next_bresp = RESP_SLVERR;
      end
    end
    next_awready = ~next_awHeld & ~next_bvalid;
    next_wready = ~next_wHeld & ~next_bvalid;
    // set wins over clear; clear pulse empties the status too
    next_irqStatus = clearPulse ? evtSet : ((irqStatus & ~irqClear) | evtSet);
    next_irq = |(next_irqStatus & next_irqEnable);
    // read channel
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid & s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr == OFF_ALARM_BYTE) begin
        next_rdata[7:0] = alarmByte;
        next_rdata[BYTE_VALID_BIT] = (scanCount != 16'h0000);
      end else if (s_axi_araddr == OFF_LIVE) begin
        next_rdata[5:0] = syncBus.alarms;
        next_rdata[LIVE_STATE_LO+1:LIVE_STATE_LO] = state;
      end else if (s_axi_araddr == OFF_CTRL) begin
        next_rdata[CTRL_ENABLE_BIT] = ctrlEnable;
      end else if (s_axi_araddr == OFF_IRQ_STATUS) begin
        next_rdata[NUM_EVT-1:0] = irqStatus;
      end else if (s_axi_araddr == OFF_IRQ_CLEAR) begin
        next_rdata = 32'h0000_0000;
      end else if (s_axi_araddr == OFF_IRQ_ENABLE) begin
        next_rdata[NUM_EVT-1:0] = irqEnable;
      end else if (s_axi_araddr == OFF_SCAN_COUNT) begin
        next_rdata[15:0] = scanCount;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    next_arready = ~next_rvalid;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      ctrlEnable <= CTRL_ENABLE_RESET;
      clearPulse <= 1'b0;
      irqStatus <= '0;
      irqEnable <= IRQ_ENABLE_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      ctrlEnable <= next_ctrlEnable;
      clearPulse <= next_clearPulse;
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
      irq <= next_irq;
    end
  end
  // =========================================================
  // checks
  logic firstTake, trackTake;
  assign firstTake = ce && !clearPulse && ctrlEnable && !scanStart &&
                     sampleStrobe && state == SCAN_FIRST;
  assign trackTake = ce && !clearPulse && ctrlEnable && !scanStart &&
                     sampleStrobe && state == SCAN_TRACK;
  chk_loop_capture: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    firstTake |=> initLoop == $past(loopNow))
    else $error("loop initial state not captured");
  chk_synth_capture: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    firstTake |=> initSynth == $past(synthNow))
    else $error("synth initial state not captured");
  chk_first_to_track: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    firstTake |=> state == SCAN_TRACK && sampleCount == SAMPLE_FIRST)
    else $error("first sample did not start tracking");
  chk_loop_sticky: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    trackTake |=> (changeLoop & $past(loopNow ^ initLoop)) ==
                  $past(loopNow ^ initLoop) &&
                  (changeLoop & $past(changeLoop)) == $past(changeLoop))
    else $error("loop change flag missed or dropped");
  chk_synth_change: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    trackTake && (synthNow != initSynth) |=> changeSynth)
    else $error("synth change flag not set");
  chk_byte_layout: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ce && byteValid |-> alarmByte == {&initSynth, initLoop, changeSynth,
                                      changeLoop})
    else $error("alarm byte layout wrong");
  chk_byte_per_scan: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    trackTake && sampleCount == SAMPLE_LAST |=>
      byteValid && state == SCAN_IDLE ##1 !(ce && byteValid))
    else $error("scan end did not yield exactly one byte");
  chk_no_early_byte: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(byteValid) |-> $past(sampleCount) == SAMPLE_LAST)
    else $error("byte issued before the last sample");
  chk_start_rearm: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ce && !clearPulse && ctrlEnable && scanStart |=>
      state == SCAN_FIRST && changeLoop == 3'h0 && !changeSynth)
    else $error("scan start did not re-arm");
  chk_irq_level: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ce |=> irq == |(irqStatus & irqEnable))
    else $error("interrupt does not follow enabled status");
endmodule

/* tb/telemetry_sink.sv */
// partner: telemetry formatter side, collects one alarm byte per scan
// assumes: byteValid is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
module telemetry_sink (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // alarm byte stream
  input wire logic byteValid,
  input wire logic [7:0] alarmByte,
  // collected view
  output logic [7:0] lastByte,
  output int byteCount
);
  // =========================================================
  // capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastByte <= 8'h00;
      byteCount <= 0;
    end else if (byteValid) begin
      lastByte <= alarmByte;
      byteCount <= byteCount + 1;
    end
  end
endmodule

/* tb/testbench.sv */
// testbench: scan sequences and register accesses on the compactor
// assumes: 40 MHz sys_clk, AXI4-Lite slave, pins synchronised in dut
`timescale 1ns/1ps
module testbench;
  import lock_alarm_pkg::*;
  // =========================================================
  // signals
  logic sys_clk = 0, rst_n = 0, ce = 1, scanStart = 0, sampleStrobe = 0;
  logic [5:0] pins = 6'h38;
  logic [7:0] alarmByte, lastByte, awaddr = 8'h00, araddr = 8'h00, eb;
  logic byteValid, irq, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  int byteCount, num_errors = 0, samples_checked = 0, b0;
  logic [5:0] initTab [4] = '{6'h38, 6'h3D, 6'h1A, 6'h2F};
  logic [5:0] chgTab [4] = '{6'h38, 6'h34, 6'h19, 6'h10};
  int kTab [4] = '{0, 100, 2, 50};
  always #12.5 sys_clk = ~sys_clk;
  // =========================================================
  // instances
  lock_alarm_scan_compactor dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .ce(ce), .synthLock(pins[5:3]), .submmLowLoopAlarm(pins[2]),
    .submmHighLoopAlarm(pins[1]), .localOscFreqLoopAlarm(pins[0]),
    .scanStart(scanStart), .sampleStrobe(sampleStrobe),
    .alarmByte(alarmByte), .byteValid(byteValid), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  telemetry_sink sink (.sys_clk(sys_clk), .rst_n(rst_n),
    .byteValid(byteValid), .alarmByte(alarmByte), .lastByte(lastByte),
    .byteCount(byteCount));
  // =========================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int t;
    logic aw, w;
    aw = 0;
    w = 0;
    t = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w) && t < 200) begin
      @(posedge sys_clk);
      t++;
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1 && t < 200) begin
      @(posedge sys_clk);
      t++;
    end
    if (t >= 200) num_errors++;
    rsp = bresp;
    bready <= 0;
    @(posedge sys_clk);
  endtask
  task automatic axi_read(input logic [7:0] a);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge sys_clk);
      t++;
    end while (arready !== 1'b1 && t < 200);
    arvalid <= 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (rvalid !== 1'b1 && t < 200);
    if (t >= 200) num_errors++;
    rd = rdata;
    rsp = rresp;
    rready <= 0;
    @(posedge sys_clk);
  endtask
  task automatic read_check(input logic [7:0] a, input logic [31:0] e);
    axi_read(a);
    check(rd, e);
  endtask
  function automatic logic [7:0] exp_byte(logic [5:0] a, logic [5:0] b,
      int k);
    logic [5:0] d;
    d = (k >= 2) ? (a ^ b) : 6'h00;
    return {&a[5:3], a[2:0], |d[5:3], d[2:0]};
  endfunction
  // pins settle through the synchroniser before each sample strobe
  task automatic scan_run(input logic [5:0] a, input logic [5:0] b,
      input int k, input int n);
    @(posedge sys_clk);
    scanStart <= 1;
    pins <= a;
    @(posedge sys_clk);
    scanStart <= 0;
    for (int i = 1; i <= n; i++) begin
      @(posedge sys_clk);
      if (i == k) pins <= b;
      repeat (3) @(posedge sys_clk);
      sampleStrobe <= 1;
      @(posedge sys_clk);
      sampleStrobe <= 0;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  // =========================================================
  // tests
  initial begin
    #(25.0 * 20000);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1;
    repeat (2) @(posedge sys_clk);
    read_check(OFF_CTRL, 32'h1);
    read_check(OFF_IRQ_ENABLE, 32'h0);
    read_check(OFF_ALARM_BYTE, 32'h0);
    read_check(8'h1C, 32'h0);
    check(rsp, RESP_SLVERR);
    axi_write(8'h1C, 32'h1);
    check(rsp, RESP_SLVERR);
    axi_write(OFF_IRQ_ENABLE, 32'h1);
    check(rsp, RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      b0 = byteCount;
      scan_run(initTab[s], chgTab[s], kTab[s], 100);
      check(byteCount, b0 + 1);
      eb = exp_byte(initTab[s], chgTab[s], kTab[s]);
      check(lastByte, eb);
      check(irq, 1'b1);
      read_check(OFF_LIVE, {22'h0, SCAN_IDLE, 2'h0, chgTab[s]});
      read_check(OFF_ALARM_BYTE, {24'h1, eb});
      axi_write(OFF_IRQ_CLEAR, 32'h1);
      repeat (2) @(posedge sys_clk);
      check(irq, 1'b0);
    end
    b0 = byteCount;
    scan_run(6'h38, 6'h3A, 2, 5);
    scan_run(6'h3C, 6'h38, 3, 100);
    check(byteCount, b0 + 1);
    check(lastByte, exp_byte(6'h3C, 6'h38, 3));
    read_check(OFF_IRQ_STATUS, 32'h3);
    read_check(OFF_SCAN_COUNT, 32'h5);
    axi_write(OFF_CTRL, 32'h3);
    read_check(OFF_ALARM_BYTE, 32'h0);
    read_check(OFF_SCAN_COUNT, 32'h0);
    read_check(OFF_IRQ_STATUS, 32'h0);
    read_check(OFF_CTRL, 32'h1);
    ce <= 1'b0;
    scanStart <= 1'b1;
    repeat (2) @(posedge sys_clk);
    ce <= 1'b1;
    scanStart <= 1'b0;
    @(posedge sys_clk);
    read_check(OFF_LIVE, {22'h0, SCAN_IDLE, 2'h0, pins});
    tally_and_finish();
  end
endmodule
